// File: rtl/tra_map.vh
`ifndef TRA_MAP_VH
`define TRA_MAP_VH
// System clock and measurement gate
`define TRA_CLK_MHZ    40
`define TRA_GATE_US    25
`define TRA_GATE_CYC   (`TRA_GATE_US * `TRA_CLK_MHZ)
// TMDS clock edges per gate at 25 MHz (250 Mbps) and at the oversampling limit
`define TRA_CNT_MIN    16'h0271
`define TRA_CNT_OVS    16'h05f7
// Frequency bands
`define TRA_BAND_NONE  2'h0
`define TRA_BAND_OVS   2'h1
`define TRA_BAND_LOW   2'h2
`define TRA_BAND_HIGH  2'h3
// Transceiver reference multiple of the TMDS clock
`define TRA_REF_X1     3'h1
`define TRA_REF_X4     3'h4
`define TRA_REF_X5     3'h5
// Oversampling factor and centre sample position
`define TRA_OVS_LAST   3'h4
`define TRA_OVS_MID    2
// Link bits per link-speed clock for two and four symbols
`define TRA_LS_DIV2    6'h14
`define TRA_LS_DIV4    6'h28
// Color depth codes
`define TRA_BPC8       2'h0
`define TRA_BPC10      2'h1
`define TRA_BPC12      2'h2
`define TRA_BPC16      2'h3
// Auxiliary packet types removed on the loop
`define TRA_PKT_ACR    8'h01
`define TRA_PKT_AUDIO  8'h02
// FIFO address width
`define TRA_FIFO_AW    4
`endif

// File: rtl/tra_fifo.v
`timescale 1ns/1ps
module tra_fifo #(
  parameter W  = 8,
  parameter AW = 4
) (
  input  wire          clock,
  input  wire          rstn,
  input  wire          wr_en,
  input  wire [W-1:0]  wdata,
  input  wire          rd_en,
  output reg  [W-1:0]  rdata_q,
  output reg           rvalid_q,
  output wire          full,
  output wire          empty
);
  reg [W-1:0] mem [0:(1<<AW)-1];
  reg [AW:0]  wp_q;
  reg [AW:0]  rp_q;

  // Extra pointer bit tells full from empty
  assign empty = (wp_q == rp_q);
  assign full  = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);

  // Storage, no reset needed
  always @(posedge clock)
  begin
    if (wr_en && !full)
      mem[wp_q[AW-1:0]] <= wdata;
  end

  // Pointers and registered read port
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      wp_q     <= {(AW+1){1'b0}};
      rp_q     <= {(AW+1){1'b0}};
      rdata_q  <= {W{1'b0}};
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= rd_en && !empty;
      if (wr_en && !full)
        wp_q <= wp_q + 1'b1;
      if (rd_en && !empty)
      begin
        rdata_q <= mem[rp_q[AW-1:0]];
        rp_q    <= rp_q + 1'b1;
      end
    end
  end
endmodule

// File: rtl/tra_datapath.v
// Contract
// - At 8 bpc one pixel per TMDS clock; TMDS clock equals video clock.
// - Deep color raises TMDS clock by 5:4, 3:2 or 2:1 over video clock; for 10 bpc the ratio outputs give 1:0.
// - Receive rate control covers link rates from 250 to 6000 Mbps.
// - Measure TMDS clock, classify a band, reconfigure PLL and transceiver.
// - Rerun detection on a new stream or clock, and on lock loss.
// - Below transceiver minimum rate, recover data with fixed 5x oversampling.
// - Oversampler width is 20 bits for two symbols, 40 for four.
// - Each recovered word comes with a one-cycle valid every five cycles.
// - Receive FIFO crosses recovered clock into receive link-speed clock.
// - Transmit FIFO crosses link-speed clock into transceiver parallel clock.
// - Oversampled receive path writes the FIFO on the every-fifth valid.
// - Direct receive path writes transceiver data with write always on.
// - Slow transmit uses oversampler, otherwise FIFO read always on.
// - PLL starts at invalid defaults, so reconfigure after power-up.
// - Bypass moves video and syncs from receive to transmit video clock.
// - Control packets, InfoFrames, aux and audio each cross link clocks.
// - Aux port backpressure throttles FIFO; never a partial packet out.
// - Drop audio sample and clock regeneration packets from aux stream.
// - Deep color only in bypass, never in frame-buffered loopback.
// - High band TMDS clock is rate/40, reference 4x; low band rate/10, 1x.
// - When oversampling, transceiver reference is 5x the TMDS clock.
// - Lock-to-reference high when oversampling is required, low otherwise.
// - Transmit oversampler repeats bits 5x; read enable every fifth cycle.
`timescale 1ns/1ps
`include "tra_map.vh"
module tra_datapath (
  input  wire         clock,
  input  wire         rstn,
  input  wire         tmds_clk_pin,
  input  wire         high_ratio_pin,
  input  wire         xcvr_locked,
  input  wire         pll_cfg_done,
  input  wire         xcvr_cfg_done,
  input  wire         four_symbols,
  input  wire         tx_oversample,
  input  wire         buffer_free_loopback_mode,
  input  wire         frame_buffered_loopback_mode,
  input  wire [1:0]   color_depth,
  input  wire         rx_rec_clk,
  input  wire [39:0]  rx_xcvr_data,
  input  wire         rx_ls_clk,
  output wire [39:0]  rx_ls_data,
  output wire         rx_ls_valid,
  input  wire         tx_ls_clk,
  input  wire [39:0]  tx_ls_data,
  input  wire         tx_ls_valid,
  output wire         tx_ls_ready,
  input  wire         tx_par_clk,
  output reg  [39:0]  tx_xcvr_data_q,
  input  wire         rx_vid_clk,
  input  wire [50:0]  rx_vid_data,
  input  wire         tx_vid_clk,
  output wire [50:0]  tx_vid_data,
  output wire         tx_vid_valid,
  input  wire [71:0]  rx_aux_data,
  input  wire         rx_aux_sop,
  input  wire         rx_aux_eop,
  input  wire         rx_aux_valid,
  output wire         rx_aux_ready,
  output wire [71:0]  tx_aux_data,
  output wire         tx_aux_sop,
  output wire         tx_aux_eop,
  output wire         tx_aux_valid,
  input  wire         tx_aux_ready,
  input  wire [63:0]  rx_aud_data,
  input  wire         rx_aud_valid,
  output wire [63:0]  tx_aud_data,
  output wire         tx_aud_valid,
  input  wire [15:0]  rx_gcp_data,
  input  wire         rx_gcp_valid,
  output wire [15:0]  tx_gcp_data,
  output wire         tx_gcp_valid,
  input  wire [31:0]  rx_info_data,
  input  wire         rx_info_valid,
  output wire [31:0]  tx_info_data,
  output wire         tx_info_valid,
  output reg  [1:0]   band_q,
  output reg          oversample_q,
  output wire         lock_to_ref,
  output reg  [2:0]   refclk_mult_q,
  output reg          rate_in_range_q,
  output reg          pll_cfg_start_q,
  output reg          xcvr_cfg_start_q,
  output wire         cfg_busy,
  output reg  [1:0]   tmds_ratio_num_q,
  output reg  [1:0]   tmds_ratio_den_q,
  output reg  [5:0]   ls_div_q,
  output reg          deep_color_ok_q
);
  localparam ST_MEAS = 2'h0;
  localparam ST_PLLW = 2'h1;
  localparam ST_XCVW = 2'h2;
  localparam ST_RUN  = 2'h3;
  localparam [9:0] GATE_LAST = `TRA_GATE_CYC - 1;

  // Band from edge count; the ratio flag marks the rate/40 clock
  function [1:0] band_of;
    input [15:0] cnt;
    input        hr;
    begin
      if (hr)
        band_of = `TRA_BAND_HIGH;
      else if (cnt < `TRA_CNT_MIN)
        band_of = `TRA_BAND_NONE;
      else if (cnt < `TRA_CNT_OVS)
        band_of = `TRA_BAND_OVS;
      else
        band_of = `TRA_BAND_LOW;
    end
  endfunction

  // Centre sample of each five-bit group
  function [7:0] pick8;
    input [39:0] w;
    integer i;
    begin
      pick8 = 8'h00;
      for (i = 0; i < 8; i = i + 1)
        pick8[i] = w[5*i+`TRA_OVS_MID];
    end
  endfunction

  // Repeat each bit of the current slice five times
  function [39:0] expand5;
    input [39:0] w;
    input [2:0]  ph;
    input        four;
    reg   [7:0]  s;
    integer i;
    begin
      s = four ? w[8*ph +: 8] : {4'h0, w[4*ph +: 4]};
      expand5 = 40'h0;
      for (i = 0; i < 8; i = i + 1)
        expand5[5*i +: 5] = {5{s[i]}};
    end
  endfunction

  // Synchronisers: clocks get a third stage for edge finding
  wire [6:0]   ck_raw = {tmds_clk_pin, rx_rec_clk, rx_ls_clk, tx_ls_clk,
                         tx_par_clk, rx_vid_clk, tx_vid_clk};
  wire [326:0] as_raw = {high_ratio_pin, xcvr_locked, pll_cfg_done,
                         xcvr_cfg_done, tx_aux_ready, rx_xcvr_data, tx_ls_data,
                         tx_ls_valid, rx_vid_data, rx_aux_sop, rx_aux_eop,
                         rx_aux_valid, rx_aux_data, rx_aud_valid, rx_aud_data,
                         rx_gcp_valid, rx_gcp_data, rx_info_valid, rx_info_data};
  reg  [6:0]   ck_s1_q;
  reg  [6:0]   ck_s2_q;
  reg  [6:0]   ck_s3_q;
  reg  [326:0] as_s1_q;
  reg  [326:0] as_s2_q;
  reg  [3:0]   lv_p_q;
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      ck_s1_q <= 7'h00;
      ck_s2_q <= 7'h00;
      ck_s3_q <= 7'h00;
      as_s1_q <= 327'h0;
      as_s2_q <= 327'h0;
      lv_p_q  <= 4'h0;
    end
    else
    begin
      ck_s1_q <= ck_raw;
      ck_s2_q <= ck_s1_q;
      ck_s3_q <= ck_s2_q;
      as_s1_q <= as_raw;
      as_s2_q <= as_s1_q;
      lv_p_q  <= as_s2_q[326:323];
    end
  end
  wire [6:0] rise = ck_s2_q & ~ck_s3_q;
  wire e_tmds = rise[6];
  wire e_rec  = rise[5];
  wire e_rxls = rise[4];
  wire e_txls = rise[3];
  wire e_txp  = rise[2];
  wire e_rxv  = rise[1];
  wire e_txv  = rise[0];
  wire        s_hr, s_lock, s_pdone, s_xdone, s_aux_rdy, s_txv, s_asop, s_aeop;
  wire        s_avld, s_audv, s_gcpv, s_infv;
  wire [39:0] s_rxd, s_txd;
  wire [50:0] s_vid;
  wire [71:0] s_aux;
  wire [63:0] s_aud;
  wire [15:0] s_gcp;
  wire [31:0] s_inf;
  assign {s_hr, s_lock, s_pdone, s_xdone, s_aux_rdy, s_rxd, s_txd, s_txv, s_vid,
          s_asop, s_aeop, s_avld, s_aux, s_audv, s_aud, s_gcpv, s_gcp, s_infv,
          s_inf} = as_s2_q;
  wire lock_lost = lv_p_q[2] & ~s_lock;
  wire pdone_re  = s_pdone & ~lv_p_q[1];
  wire xdone_re  = s_xdone & ~lv_p_q[0];

  // Gate counter and TMDS edge counter measure the reference frequency
  reg  [9:0]  gate_q;
  reg  [15:0] edges_q;
  reg  [15:0] meas_q;
  reg         meas_new_q;
  reg  [1:0]  st_q;
  wire        gate_end = (gate_q == GATE_LAST);
  wire [1:0]  nb = band_of(meas_q, s_hr);
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      gate_q     <= 10'h000;
      edges_q    <= 16'h0000;
      meas_q     <= 16'h0000;
      meas_new_q <= 1'b0;
    end
    else
    begin
      meas_new_q <= gate_end;
      gate_q     <= gate_end ? 10'h000 : gate_q + 10'h001;
      if (gate_end)
      begin
        meas_q  <= edges_q + {15'h0000, e_tmds};
        edges_q <= 16'h0000;
      end
      else if (e_tmds && edges_q != 16'hffff)
        edges_q <= edges_q + 16'h0001;
    end
  end

  // Rate controller: measure, reconfigure PLL, then transceiver, then watch
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      st_q             <= ST_MEAS;
      band_q           <= `TRA_BAND_NONE;
      pll_cfg_start_q  <= 1'b0;
      xcvr_cfg_start_q <= 1'b0;
    end
    else
    begin
      pll_cfg_start_q  <= 1'b0;
      xcvr_cfg_start_q <= 1'b0;
      case (st_q)
        ST_MEAS:
          if (meas_new_q && nb != `TRA_BAND_NONE)
          begin
            band_q          <= nb;
            pll_cfg_start_q <= 1'b1;
            st_q            <= ST_PLLW;
          end
        ST_PLLW:
          if (pdone_re)
          begin
            xcvr_cfg_start_q <= 1'b1;
            st_q             <= ST_XCVW;
          end
        ST_XCVW:
          if (xdone_re)
            st_q <= ST_RUN;
        ST_RUN:
          if (lock_lost)
            st_q <= ST_MEAS;
          else if (meas_new_q && nb != band_q)
            st_q <= ST_MEAS;
        default:
          st_q <= ST_MEAS;
      endcase
    end
  end
  assign cfg_busy    = (st_q != ST_RUN);
  assign lock_to_ref = oversample_q;

  // Mode and clock-ratio outputs derived from band and configuration
  wire       bypass = buffer_free_loopback_mode & ~frame_buffered_loopback_mode;
  wire [1:0] depth  = bypass ? color_depth : `TRA_BPC8;
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      oversample_q     <= 1'b0;
      refclk_mult_q    <= `TRA_REF_X1;
      rate_in_range_q  <= 1'b0;
      tmds_ratio_num_q <= 2'h1;
      tmds_ratio_den_q <= 2'h1;
      ls_div_q         <= `TRA_LS_DIV2;
      deep_color_ok_q  <= 1'b0;
    end
    else
    begin
      oversample_q    <= (band_q == `TRA_BAND_OVS);
      rate_in_range_q <= (band_q != `TRA_BAND_NONE);
      if (band_q == `TRA_BAND_OVS)
        refclk_mult_q <= `TRA_REF_X5;
      else if (band_q == `TRA_BAND_HIGH)
        refclk_mult_q <= `TRA_REF_X4;
      else
        refclk_mult_q <= `TRA_REF_X1;
      ls_div_q        <= four_symbols ? `TRA_LS_DIV4 : `TRA_LS_DIV2;
      deep_color_ok_q <= bypass;
      case (depth)
        `TRA_BPC10: {tmds_ratio_num_q, tmds_ratio_den_q} <= {2'h1, 2'h0};
        `TRA_BPC12: {tmds_ratio_num_q, tmds_ratio_den_q} <= {2'h3, 2'h2};
        `TRA_BPC16: {tmds_ratio_num_q, tmds_ratio_den_q} <= {2'h2, 2'h1};
        default:    {tmds_ratio_num_q, tmds_ratio_den_q} <= {2'h1, 2'h1};
      endcase
    end
  end

  // Receive oversampler: centre samples shifted into a 20 or 40 bit word
  reg  [39:0] acc_q;
  reg  [2:0]  ocnt_q;
  wire [7:0]  pk = pick8(s_rxd);
  wire [39:0] acc_d = four_symbols ? {pk, acc_q[39:8]}
                                   : {20'h00000, pk[3:0], acc_q[19:4]};
  wire        ovs_valid = oversample_q & e_rec & (ocnt_q == `TRA_OVS_LAST);
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      acc_q  <= 40'h0;
      ocnt_q <= 3'h0;
    end
    else if (oversample_q && e_rec)
    begin
      acc_q  <= acc_d;
      ocnt_q <= (ocnt_q == `TRA_OVS_LAST) ? 3'h0 : ocnt_q + 3'h1;
    end
  end

  // Receive FIFO: recovered clock in, receive link clock out
  wire        rxf_full, rxf_empty, rxf_rv;
  wire        rxf_wr = e_rec & (oversample_q ? ovs_valid : 1'b1);
  wire [39:0] rxf_wd = oversample_q ? acc_d : s_rxd;
  tra_fifo #(.W(40), .AW(`TRA_FIFO_AW)) u_rx_fifo (
    .clock(clock), .rstn(rstn), .wr_en(rxf_wr), .wdata(rxf_wd),
    .rd_en(e_rxls), .rdata_q(rx_ls_data), .rvalid_q(rxf_rv),
    .full(rxf_full), .empty(rxf_empty));

  // Transmit FIFO: link clock in, transceiver parallel clock out
  wire        txf_full, txf_empty, txf_rv;
  wire [39:0] txf_rd;
  reg  [2:0]  tph_q;
  reg  [39:0] thold_q;
  reg         e_txp_d_q;
  wire        txf_re = e_txp & (~tx_oversample | (tph_q == 3'h0));
  assign tx_ls_ready = ~txf_full;
  tra_fifo #(.W(40), .AW(`TRA_FIFO_AW)) u_tx_fifo (
    .clock(clock), .rstn(rstn), .wr_en(e_txls & s_txv), .wdata(s_txd),
    .rd_en(txf_re), .rdata_q(txf_rd), .rvalid_q(txf_rv),
    .full(txf_full), .empty(txf_empty));

  // Transmit oversampler emits one slice per parallel clock, five per word
  wire [39:0] tword = txf_rv ? txf_rd : thold_q;
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      tph_q          <= 3'h0;
      thold_q        <= 40'h0;
      e_txp_d_q      <= 1'b0;
      tx_xcvr_data_q <= 40'h0;
    end
    else
    begin
      e_txp_d_q <= e_txp;
      if (e_txp_d_q)
      begin
        thold_q <= tword;
        if (tx_oversample)
        begin
          tx_xcvr_data_q <= expand5(tword, tph_q, four_symbols);
          tph_q <= (tph_q == `TRA_OVS_LAST) ? 3'h0 : tph_q + 3'h1;
        end
        else
        begin
          tx_xcvr_data_q <= tword;
          tph_q          <= 3'h0;
        end
      end
    end
  end

  // Bypass video FIFO between receive and transmit video clocks
  wire vf_rv, vf_full, vf_empty;
  tra_fifo #(.W(51), .AW(`TRA_FIFO_AW)) u_vid_fifo (
    .clock(clock), .rstn(rstn), .wr_en(e_rxv & bypass), .wdata(s_vid),
    .rd_en(e_txv), .rdata_q(tx_vid_data), .rvalid_q(vf_rv),
    .full(vf_full), .empty(vf_empty));

  // Aux filter drops audio and clock regeneration packets whole
  reg        drop_q;
  reg  [4:0] pkts_q;
  wire       a_filt = (s_aux[7:0] == `TRA_PKT_AUDIO) || (s_aux[7:0] == `TRA_PKT_ACR);
  wire       a_drop = s_asop ? a_filt : drop_q;
  wire       af_full, af_empty, af_rv;
  wire       af_wr = e_rxls & s_avld & bypass & ~a_drop & ~af_full;
  wire       af_rd = e_txls & s_aux_rdy & (pkts_q != 5'h00);
  wire [73:0] af_q;
  assign rx_aux_ready = ~af_full;
  assign {tx_aux_sop, tx_aux_eop, tx_aux_data} = af_q;
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      drop_q <= 1'b0;
      pkts_q <= 5'h00;
    end
    else
    begin
      if (e_rxls && s_avld && s_asop)
        drop_q <= a_filt;
      // Count complete packets held so output never starts a partial one
      pkts_q <= pkts_q + {4'h0, af_wr & s_aeop} - {4'h0, af_rv & af_q[72]};
    end
  end
  tra_fifo #(.W(74), .AW(`TRA_FIFO_AW)) u_aux_fifo (
    .clock(clock), .rstn(rstn), .wr_en(af_wr), .wdata({s_asop, s_aeop, s_aux}),
    .rd_en(af_rd), .rdata_q(af_q), .rvalid_q(af_rv),
    .full(af_full), .empty(af_empty));

  // Audio, control packet and InfoFrame FIFOs across link clocks
  wire au_rv, au_full, au_empty, gc_rv, gc_full, gc_empty, in_rv, in_full, in_empty;
  tra_fifo #(.W(64), .AW(`TRA_FIFO_AW)) u_aud_fifo (
    .clock(clock), .rstn(rstn), .wr_en(e_rxls & s_audv & bypass), .wdata(s_aud),
    .rd_en(e_txls), .rdata_q(tx_aud_data), .rvalid_q(au_rv),
    .full(au_full), .empty(au_empty));
  tra_fifo #(.W(16), .AW(`TRA_FIFO_AW)) u_gcp_fifo (
    .clock(clock), .rstn(rstn), .wr_en(e_rxls & s_gcpv & bypass), .wdata(s_gcp),
    .rd_en(e_txls), .rdata_q(tx_gcp_data), .rvalid_q(gc_rv),
    .full(gc_full), .empty(gc_empty));
  tra_fifo #(.W(32), .AW(`TRA_FIFO_AW)) u_info_fifo (
    .clock(clock), .rstn(rstn), .wr_en(e_rxls & s_infv & bypass), .wdata(s_inf),
    .rd_en(e_txls), .rdata_q(tx_info_data), .rvalid_q(in_rv),
    .full(in_full), .empty(in_empty));

  // Output valids hold from a pop until the next edge of the reading clock
  wire [5:0] pop = {rxf_rv, vf_rv, af_rv, au_rv, gc_rv, in_rv};
  wire [5:0] rde = {e_rxls, e_txv, e_txls, e_txls, e_txls, e_txls};
  reg  [5:0] vld_q;
  always @(posedge clock)
  begin
    if (!rstn)
      vld_q <= 6'h00;
    else
      vld_q <= pop | (vld_q & ~rde);
  end
  assign {rx_ls_valid, tx_vid_valid, tx_aux_valid, tx_aud_valid, tx_gcp_valid,
          tx_info_valid} = vld_q;
endmodule

// File: verif/tra_monitor.sv
`timescale 1ns/1ps
module tra_monitor (
  input wire       clock,
  input wire       rstn,
  input wire       buffer_free_loopback_mode,
  input wire       frame_buffered_loopback_mode,
  input wire       four_symbols,
  input wire [1:0] band_q,
  input wire       oversample_q,
  input wire       lock_to_ref,
  input wire [2:0] refclk_mult_q,
  input wire       pll_cfg_start_q,
  input wire       xcvr_cfg_start_q,
  input wire       cfg_busy,
  input wire [1:0] tmds_ratio_num_q,
  input wire [1:0] tmds_ratio_den_q,
  input wire [5:0] ls_div_q,
  input wire       deep_color_ok_q
);
  wire bp;
  // Loopback counts only in buffer-free mode
  assign bp = buffer_free_loopback_mode & ~frame_buffered_loopback_mode;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  chk_lock_ovs: assert property (oversample_q |-> lock_to_ref && refclk_mult_q == 3'h5)
    else $error("lock or reference wrong while oversampling");
  chk_lock_off: assert property (!oversample_q |-> !lock_to_ref)
    else $error("lock to reference high without oversampling");
  chk_pll_pulse: assert property (pll_cfg_start_q |-> band_q != 2'h0 ##1 !pll_cfg_start_q)
    else $error("pll start pulse wrong");
  chk_xcvr_pulse: assert property (xcvr_cfg_start_q |=> !xcvr_cfg_start_q && cfg_busy)
    else $error("transceiver start pulse wrong");
  chk_high_band: assert property (!cfg_busy && band_q == 2'h3 |-> refclk_mult_q == 3'h4)
    else $error("high band reference multiple wrong");
  chk_low_band: assert property (!cfg_busy && band_q == 2'h2 |-> refclk_mult_q == 3'h1)
    else $error("low band reference multiple wrong");
  chk_run_band: assert property (!cfg_busy |-> band_q != 2'h0 && oversample_q == (band_q == 2'h1))
    else $error("running without a valid band");
  chk_ratio_one: assert property ((!bp)[*3] |-> {tmds_ratio_num_q, tmds_ratio_den_q} == 4'h5)
    else $error("deep ratio outside loopback");
  chk_deep_gate: assert property ((!bp)[*3] |-> !deep_color_ok_q)
    else $error("deep color offered outside loopback");
  chk_ls_width: assert property ($stable(four_symbols)[*3] |-> ls_div_q == (four_symbols ? 6'h28 : 6'h14))
    else $error("link divider wrong");
  cov_pll: cover property (pll_cfg_start_q);
  cov_run: cover property (!cfg_busy);
  cov_deep: cover property (deep_color_ok_q);
endmodule
bind tra_datapath tra_monitor tra_monitor_inst (.*);

// File: verif/tra_far_model.sv
`timescale 1ns/1ps
module tra_far_model (
  input wire   clock,
  input wire   rstn,
  input wire   tmds_en,
  input wire   pll_cfg_start_q,
  input wire   xcvr_cfg_start_q,
  output logic tmds_clk_pin,
  output logic pll_cfg_done,
  output logic xcvr_cfg_done,
  output logic xcvr_locked
);
  logic [1:0] div_q;
  // 5 MHz reference clock, still while disabled; answers each start one cycle later
  always @(posedge clock)
  begin
    div_q <= (rstn && tmds_en) ? div_q + 2'h1 : 2'h0;
    tmds_clk_pin <= (rstn && tmds_en) ? tmds_clk_pin ^ (div_q == 2'h3) : 1'b0;
    pll_cfg_done <= pll_cfg_start_q;
    xcvr_cfg_done <= xcvr_cfg_start_q;
    // Lock drops while the reference is switched off
    xcvr_locked <= rstn && tmds_en;
  end
endmodule

// File: verif/tra_datapath_tb_top.sv
`timescale 1ns/1ps
module tra_datapath_tb_top;
  logic clock, rstn, tmds_en, high_ratio_pin, four_symbols, tx_oversample, tx_aux_ready;
  logic buffer_free_loopback_mode, frame_buffered_loopback_mode, tx_ls_valid;
  logic rx_aux_sop, rx_aux_eop, rx_aux_valid, rx_aud_valid, rx_gcp_valid, rx_info_valid;
  logic [5:0]  pc;
  logic [1:0]  color_depth;
  logic [39:0] rx_xcvr_data, tx_ls_data;
  logic [50:0] rx_vid_data;
  logic [71:0] rx_aux_data;
  logic [63:0] rx_aud_data;
  logic [15:0] rx_gcp_data;
  logic [31:0] rx_info_data;
  wire rx_rec_clk, rx_ls_clk, tx_ls_clk, tx_par_clk, rx_vid_clk, tx_vid_clk;
  wire tmds_clk_pin, xcvr_locked, pll_cfg_done, xcvr_cfg_done, rx_ls_valid, tx_ls_ready;
  wire tx_vid_valid, rx_aux_ready, tx_aux_sop, tx_aux_eop, tx_aux_valid, tx_aud_valid;
  wire tx_gcp_valid, tx_info_valid, oversample_q, lock_to_ref, rate_in_range_q;
  wire pll_cfg_start_q, xcvr_cfg_start_q, cfg_busy, deep_color_ok_q;
  wire [39:0] rx_ls_data, tx_xcvr_data_q;
  wire [50:0] tx_vid_data;
  wire [71:0] tx_aux_data;
  wire [63:0] tx_aud_data;
  wire [15:0] tx_gcp_data;
  wire [31:0] tx_info_data;
  wire [1:0]  band_q, tmds_ratio_num_q, tmds_ratio_den_q;
  wire [2:0]  refclk_mult_q;
  wire [5:0]  ls_div_q;
  int errors, checked, starts, i;
  logic [3:0] rt [4] = '{4'h5, 4'h4, 4'he, 4'h9};
  logic [7:0] at [7] = '{8'h05, 8'h05, 8'h02, 8'h01, 8'h01, 8'h07, 8'h09};
  logic [1:0] ap [7] = '{2'h2, 2'h1, 2'h3, 2'h2, 2'h1, 2'h3, 2'h2};
  int ae [3] = '{0, 1, 5};

  assign {tx_vid_clk, rx_vid_clk, tx_par_clk, tx_ls_clk, rx_ls_clk, rx_rec_clk} = pc;
  tra_datapath tra_datapath_inst (.*);
  tra_far_model tra_far_model_inst (.*);

  // System clock
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Reconfiguration requests seen
  always @(posedge clock)
    if (pll_cfg_start_q === 1'b1)
      starts <= starts + 1;

  task cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task chk(input string nm, input logic [79:0] seen, input logic [79:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One 200 ns period on the selected pin clocks
  task tick(input logic [5:0] m);
    cyc(2);
    pc = pc | m;
    cyc(4);
    pc = pc & ~m;
    cyc(2);
  endtask

  task results;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #1_000_000;
    errors++;
    results();
  end

  initial
  begin
    {pc, rstn, tmds_en, high_ratio_pin, four_symbols, tx_oversample, tx_aux_ready} = 0;
    {buffer_free_loopback_mode, frame_buffered_loopback_mode, color_depth, tx_ls_valid} = 0;
    {rx_aux_sop, rx_aux_eop, rx_aux_valid, rx_aud_valid, rx_gcp_valid, rx_info_valid} = 0;
    {rx_xcvr_data, tx_ls_data, rx_vid_data, rx_aux_data} = 0;
    {rx_aud_data, rx_gcp_data, rx_info_data} = 0;
    {errors, checked, starts} = 0;
    cyc(6);
    rstn = 1'b1;
    cyc(2);
    chk("band", band_q, 2'h0);
    chk("refclk", refclk_mult_q, 3'h1);
    chk("ratio", {tmds_ratio_num_q, tmds_ratio_den_q}, 4'h5);
    chk("ready", {tx_ls_ready, rx_aux_ready, cfg_busy}, 3'h7);
    $display("test reset done");
    // A 5 MHz reference is below the lowest band: no reconfiguration
    tmds_en = 1'b1;
    cyc(2500);
    chk("slow band", {band_q, cfg_busy, lock_to_ref}, 4'h2);
    chk("slow starts", starts, 0);
    $display("test slow rate done");
    // Receive FIFO, direct path: 18 writes, 16 kept
    for (i = 0; i < 18; i++)
    begin
      rx_xcvr_data = 40'h1000 + i;
      tick(6'h01);
    end
    for (i = 0; i < 18; i++)
    begin
      tick(6'h02);
      chk("rx valid", rx_ls_valid, i < 16);
      if (i < 16)
        chk("rx data", rx_ls_data, 40'h1000 + i);
    end
    $display("test receive fifo done");
    // Transmit FIFO, direct path: three words, then last word held
    tx_ls_valid = 1'b1;
    for (i = 0; i < 3; i++)
    begin
      tx_ls_data = 40'h2000 + i;
      tick(6'h04);
    end
    tx_ls_valid = 1'b0;
    for (i = 0; i < 4; i++)
    begin
      tick(6'h08);
      chk("tx data", tx_xcvr_data_q, 40'h2000 + (i < 3 ? i : 2));
    end
    $display("test transmit fifo done");
    // Video loop ignored outside loopback, carried inside it
    rx_vid_data = 51'h1;
    tick(6'h10);
    tick(6'h20);
    chk("vid off", tx_vid_valid, 1'b0);
    buffer_free_loopback_mode = 1'b1;
    rx_vid_data = 51'h7_1234_5678_9abc;
    tick(6'h10);
    tick(6'h20);
    chk("vid", {tx_vid_valid, tx_vid_data}, {1'b1, 51'h7_1234_5678_9abc});
    $display("test video loop done");
    // Control, audio and infoframe words cross link clocks
    {rx_aud_valid, rx_gcp_valid, rx_info_valid} = 3'h7;
    {rx_aud_data, rx_gcp_data, rx_info_data} = {64'h0123_4567_89ab_cdef, 16'hbeef, 32'h5a5a_c3c3};
    tick(6'h02);
    {rx_aud_valid, rx_gcp_valid, rx_info_valid} = 3'h0;
    tick(6'h04);
    chk("aud", {tx_aud_valid, tx_aud_data}, {1'b1, 64'h0123_4567_89ab_cdef});
    chk("gcp", {tx_gcp_valid, tx_gcp_data}, {1'b1, 16'hbeef});
    chk("info", {tx_info_valid, tx_info_data}, {1'b1, 32'h5a5a_c3c3});
    $display("test packet loop done");
    // Aux: held back, audio types dropped, trailing partial packet kept back
    rx_aux_valid = 1'b1;
    for (i = 0; i < 7; i++)
    begin
      rx_aux_data = {64'(i), at[i]};
      {rx_aux_sop, rx_aux_eop} = ap[i];
      tick(6'h02);
    end
    rx_aux_valid = 1'b0;
    tick(6'h04);
    tick(6'h04);
    chk("aux held", tx_aux_valid, 1'b0);
    tx_aux_ready = 1'b1;
    for (i = 0; i < 4; i++)
    begin
      tick(6'h04);
      chk("aux valid", tx_aux_valid, i < 3);
      if (i < 3)
        chk("aux word", {tx_aux_sop, tx_aux_eop, tx_aux_data}, {ap[ae[i]], 64'(ae[i]), at[ae[i]]});
    end
    $display("test aux loop done");
    // Deep color ratios in loopback, four symbols per clock
    four_symbols = 1'b1;
    for (i = 0; i < 4; i++)
    begin
      color_depth = i[1:0];
      cyc(4);
      chk("deep ratio", {tmds_ratio_num_q, tmds_ratio_den_q}, rt[i]);
      chk("deep ok", {deep_color_ok_q, ls_div_q}, {1'b1, 6'h28});
    end
    frame_buffered_loopback_mode = 1'b1;
    cyc(4);
    chk("buffered", {deep_color_ok_q, tmds_ratio_num_q, tmds_ratio_den_q}, 5'h05);
    $display("test color depth done");
    // Transmit oversampler spreads slices of the held word 2002 five-fold
    tx_oversample = 1'b1;
    tick(6'h08);
    chk("tx ovs slice0", tx_xcvr_data_q, 40'h3e0);
    tick(6'h08);
    chk("tx ovs slice1", tx_xcvr_data_q, 40'h3e00_0000);
    $display("test transmit oversampler done");
    // Ratio pin forces the high band: full reconfiguration, then lock loss reruns it
    high_ratio_pin = 1'b1;
    cyc(2020);
    chk("high band", {band_q, cfg_busy, lock_to_ref, rate_in_range_q, refclk_mult_q},
        {2'h3, 3'h1, 3'h4});
    chk("high starts", {oversample_q, starts[7:0]}, 9'h001);
    tmds_en = 1'b0;
    cyc(8);
    chk("lock loss", cfg_busy, 1'b1);
    tmds_en = 1'b1;
    cyc(1040);
    chk("rerun", {cfg_busy, band_q, starts[7:0]}, {1'b0, 2'h3, 8'h02});
    $display("test rate control done");
    results();
  end
endmodule
